// [inc/aml_pkg.sv]
package aml_pkg;
  // Framing and opcode bytes
  localparam logic [7:0] ENQ_B = 8'h05;
  localparam logic [7:0] STX_B = 8'h02;
  localparam logic [7:0] ETX_B = 8'h03;
  localparam logic [7:0] ACK_B = 8'h06;
  localparam logic [7:0] NAK_B = 8'h15;
  localparam logic [7:0] CR_B  = 8'h0D;
  localparam logic [7:0] OP_RD = 8'h52;
  localparam logic [7:0] OP_WR = 8'h57;
  // Word limit per frame and reply buffer depth
  localparam int MAX_WORDS  = 255;
  localparam int FIFO_DEPTH = 32;
  // Last character index of each hex field
  localparam logic [1:0] ADDR_LAST = 2'h3;
  localparam logic [1:0] CNT_LAST  = 2'h1;
  localparam logic [1:0] WORD_LAST = 2'h3;
  localparam logic [1:0] CHK_LAST  = 2'h1;
  // Error code bytes, values arbitrary
  localparam logic [7:0] EC_HEX   = 8'h31;
  localparam logic [7:0] EC_CHK   = 8'h32;
  localparam logic [7:0] EC_OP    = 8'h33;
  localparam logic [7:0] EC_CNT   = 8'h34;
  localparam logic [7:0] EC_FRAME = 8'h35;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h00, RX_OP = 5'h01, RX_ADDR = 5'h02, RX_CNT = 5'h03,
    RX_DATA = 5'h04, RX_CHK = 5'h05, RX_CR = 5'h06, COMMIT = 5'h07,
    TX_HEAD = 5'h08, TX_CODE = 5'h09, TX_OP = 5'h0A, TX_ADDR = 5'h0B,
    TX_CNT = 5'h0C, TX_DATA = 5'h0D, TX_ETX = 5'h0E, TX_BCC = 5'h0F,
    TX_CR = 5'h10
  } aml_state_t;

  // ASCII hex to nibble, bit 4 set when the character is valid hex
  function automatic logic [4:0] aml_hex2nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      return {1'b1, c[3:0] + 4'h9};
    return 5'h00;
  endfunction : aml_hex2nib

  // Nibble to upper-case ASCII hex
  function automatic logic [7:0] aml_nib2hex(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : aml_nib2hex

  // Nibble i of a word, most significant first
  function automatic logic [3:0] aml_nib16(input logic [15:0] v, input logic [1:0] i);
    case (i)
      2'h0:    return v[15:12];
      2'h1:    return v[11:8];
      2'h2:    return v[7:4];
      default: return v[3:0];
    endcase
  endfunction : aml_nib16
endpackage : aml_pkg

// [inc/aml_stream_if.sv]
`timescale 1ns/1ps
interface aml_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : aml_stream_if

// [src/aml_fifo.sv]
`timescale 1ns/1ps
module aml_fifo import aml_pkg::*; #(
  parameter int W     = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic   clock,
  input  wire logic   rst_n,
  aml_stream_if.snk   in_s,
  aml_stream_if.src   out_s
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("aml_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wr_reg;
  logic [PW:0]  rd_reg;

  wire full  = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire push  = in_s.valid && !full;
  wire pop   = out_s.ready && !empty;

  // Full and empty are exact, so a stalled drain really stops the writer
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rd_reg[PW-1:0]];

  // Pointers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) mem[wr_reg[PW-1:0]] <= in_s.data;
  end
endmodule : aml_fifo

// [src/aml_link.sv]
`timescale 1ns/1ps
// Functional notes
// - Read frame: 05h, 52h, four hex address, two hex count, optional check, 0Dh.
// - A read asks for at most 255 words.
// - Read reply: 02h, 52h, echoed address and count, four hex per word upward.
// - With checking on, read reply puts 03h after data, except under type 2.
// - Check field is XOR from start byte up to the field, as two hex chars.
// - Bad read request gets 15h; error code and 0Dh only under type 1.
// - Write frame: 05h, 57h, address, count, four hex per word, optional check, 0Dh.
// - A write carries at most 255 words, stored at consecutive addresses.
// - Good write gets 06h; 57h and 0Dh follow only under type 1.
// - Bad write request gets 15h; error code and 0Dh only under type 1.
// - Type 2 never adds the 03h byte, even with checking on.
module aml_link import aml_pkg::*; #(
  parameter int AW        = 10,
  parameter int MAX_WORDS_P = MAX_WORDS,
  parameter int DEPTH     = FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       bcc_en,
  input  wire logic       proto_type2,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready
);
  if (AW < 1 || AW > 16 || MAX_WORDS_P < 1 || MAX_WORDS_P > MAX_WORDS) begin : g_bad_par
    $error("aml_link parameters out of range");
  end

  // Word store and write staging area
  logic [15:0]   panel_word_memory [2**AW];
  logic [15:0]   stage_mem [MAX_WORDS + 1];

  aml_state_t    st_reg, st_next;
  logic [1:0]    cidx_reg, cidx_next;
  logic [7:0]    widx_reg, widx_next;
  logic [15:0]   addr_reg, addr_next;
  logic [7:0]    cnt_reg, cnt_next;
  logic [15:0]   word_reg, word_next;
  logic [7:0]    chk_reg, chk_next;
  logic [7:0]    rxx_reg, rxx_next;
  logic [7:0]    txx_reg, txx_next;
  logic          rd_reg, rd_next;
  logic          err_reg, err_next;
  logic [7:0]    ecode_reg, ecode_next;
  logic [7:0]    push_data;

  aml_stream_if #(.W(8)) push_s ();
  aml_stream_if #(.W(8)) pop_s ();

  // Reply buffer lets the reply builder run ahead of a slow host
  aml_fifo #(.W(8), .DEPTH(DEPTH)) aml_fifo_i (
    .clock (clock),
    .rst_n (rst_n),
    .in_s  (push_s),
    .out_s (pop_s)
  );

  // Receive side decode
  wire        in_rx    = (st_reg <= RX_CR);
  wire        take     = rx_valid && rx_ready;
  wire [4:0]  hx       = aml_hex2nib(rx_data);
  wire [3:0]  nib      = hx[3:0];
  wire        is_enq   = (rx_data == ENQ_B);
  wire        is_cr    = (rx_data == CR_B);
  wire        hex_st   = (st_reg == RX_ADDR) || (st_reg == RX_CNT) ||
                         (st_reg == RX_DATA) || (st_reg == RX_CHK);
  wire [7:0]  cnt_full = {cnt_reg[3:0], nib};
  wire [7:0]  chk_full = {chk_reg[3:0], nib};
  wire [7:0]  cnt_lim  = 8'(MAX_WORDS_P);
  wire        last_wd  = (widx_reg == cnt_reg - 8'h01);

  // Error sources, first one seen names the code
  wire bad_hex   = take && hex_st && !is_cr && !is_enq && !hx[4];
  wire bad_op    = take && (st_reg == RX_OP) && !is_enq && rx_data != OP_RD &&
                   rx_data != OP_WR;
  wire bad_cnt   = take && (st_reg == RX_CNT) && (cidx_reg == CNT_LAST) && hx[4] &&
                   (cnt_full > cnt_lim);
  wire bad_chk   = take && (st_reg == RX_CHK) && (cidx_reg == CHK_LAST) && hx[4] &&
                   (chk_full != rxx_reg);
  wire bad_frame = take && (st_reg == RX_CR) && !is_cr && !is_enq;
  wire [7:0] hit_code = bad_hex ? EC_HEX : bad_op ? EC_OP : bad_cnt ? EC_CNT :
                        bad_chk ? EC_CHK : EC_FRAME;
  wire any_bad   = bad_hex || bad_op || bad_cnt || bad_chk || bad_frame;

  // Tail of a request and of a read reply depend on the check option
  // Both options are read live, so change them only while the link is idle
  wire [4:0]  rx_tail = bcc_en ? RX_CHK : RX_CR;
  wire [4:0]  tx_tail = !bcc_en ? TX_CR : (proto_type2 ? TX_BCC : TX_ETX);
  wire [15:0] rd_word = panel_word_memory[AW'(addr_reg + {8'h00, widx_reg})];
  wire        push_ok = push_s.ready;

  // Replies go out through the buffer; rx stalls while a reply is built
  assign rx_ready     = in_rx;
  assign push_s.valid = !in_rx && (st_reg != COMMIT);
  assign push_s.data  = push_data;
  assign tx_valid     = pop_s.valid;
  assign tx_data      = pop_s.data;
  assign pop_s.ready  = tx_ready;

  // Reply byte for the present state
  always_comb begin
    case (st_reg)
      TX_HEAD: push_data = err_reg ? NAK_B : (rd_reg ? STX_B : ACK_B);
      TX_CODE: push_data = ecode_reg;
      TX_OP:   push_data = rd_reg ? OP_RD : OP_WR;
      TX_ADDR: push_data = aml_nib2hex(aml_nib16(addr_reg, cidx_reg));
      TX_CNT:  push_data = aml_nib2hex(cidx_reg[0] ? cnt_reg[3:0] : cnt_reg[7:4]);
      TX_DATA: push_data = aml_nib2hex(aml_nib16(rd_word, cidx_reg));
      TX_ETX:  push_data = ETX_B;
      TX_BCC:  push_data = aml_nib2hex(cidx_reg[0] ? txx_reg[3:0] : txx_reg[7:4]);
      TX_CR:   push_data = CR_B;
      default: push_data = 8'h00;
    endcase
  end

  // Sequencer
  always_comb begin
    st_next = st_reg;
    cidx_next = cidx_reg;
    widx_next = widx_reg;
    addr_next = addr_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    chk_next = chk_reg;
    rxx_next = rxx_reg;
    txx_next = txx_reg;
    rd_next = rd_reg;
    err_next = err_reg;
    ecode_next = ecode_reg;
    if (take) begin
      if (st_reg != RX_CHK) rxx_next = rxx_reg ^ rx_data;
      if (any_bad && !err_reg) begin
        err_next = 1'b1;
        ecode_next = hit_code;
      end
      if (is_enq) begin
        // A start byte anywhere drops the partial frame
        st_next = RX_OP;
        rxx_next = rx_data;
        err_next = 1'b0;
        cidx_next = 2'h0;
        widx_next = 8'h00;
      end else if (st_reg != RX_IDLE && st_reg != RX_CR && is_cr) begin
        // Early end of frame: answer negatively
        err_next = 1'b1;
        if (!err_reg) ecode_next = EC_FRAME;
        st_next = TX_HEAD;
      end else begin
        case (st_reg)
          RX_OP: begin
            rd_next = (rx_data != OP_WR);
            st_next = RX_ADDR;
          end
          RX_ADDR: begin
            addr_next = {addr_reg[11:0], nib};
            cidx_next = cidx_reg + 2'h1;
            if (cidx_reg == ADDR_LAST) st_next = RX_CNT;
          end
          RX_CNT: begin
            cnt_next = cnt_full;
            cidx_next = cidx_reg + 2'h1;
            if (cidx_reg == CNT_LAST) begin
              cidx_next = 2'h0;
              st_next = (!rd_reg && cnt_full != 8'h00) ? RX_DATA : aml_state_t'(rx_tail);
            end
          end
          RX_DATA: begin
            word_next = {word_reg[11:0], nib};
            cidx_next = cidx_reg + 2'h1;
            if (cidx_reg == WORD_LAST) begin
              widx_next = widx_reg + 8'h01;
              if (last_wd) st_next = aml_state_t'(rx_tail);
            end
          end
          RX_CHK: begin
            chk_next = chk_full;
            cidx_next = cidx_reg + 2'h1;
            if (cidx_reg == CHK_LAST) st_next = RX_CR;
          end
          RX_CR: begin
            if (is_cr) begin
              widx_next = 8'h00;
              st_next = (err_reg || rd_reg || cnt_reg == 8'h00) ? TX_HEAD : COMMIT;
            end
          end
          default: st_next = st_reg;
        endcase
      end
    end else if (st_reg == COMMIT) begin
      widx_next = widx_reg + 8'h01;
      if (last_wd) st_next = TX_HEAD;
    end else if (!in_rx && push_ok) begin
      if (st_reg != TX_BCC && st_reg != TX_CR) txx_next = txx_reg ^ push_data;
      case (st_reg)
        TX_HEAD: begin
          txx_next = push_data;
          cidx_next = 2'h0;
          widx_next = 8'h00;
          if (err_reg) st_next = proto_type2 ? RX_IDLE : TX_CODE;
          else if (rd_reg) st_next = TX_OP;
          else st_next = proto_type2 ? RX_IDLE : TX_OP;
        end
        TX_CODE: st_next = TX_CR;
        TX_OP:   st_next = rd_reg ? TX_ADDR : TX_CR;
        TX_ADDR: begin
          cidx_next = cidx_reg + 2'h1;
          if (cidx_reg == ADDR_LAST) st_next = TX_CNT;
        end
        TX_CNT: begin
          cidx_next = cidx_reg + 2'h1;
          if (cidx_reg == CNT_LAST) begin
            cidx_next = 2'h0;
            st_next = (cnt_reg == 8'h00) ? aml_state_t'(tx_tail) : TX_DATA;
          end
        end
        TX_DATA: begin
          cidx_next = cidx_reg + 2'h1;
          if (cidx_reg == WORD_LAST) begin
            widx_next = widx_reg + 8'h01;
            if (last_wd) st_next = aml_state_t'(tx_tail);
          end
        end
        TX_ETX: st_next = TX_BCC;
        TX_BCC: begin
          cidx_next = cidx_reg + 2'h1;
          if (cidx_reg == CHK_LAST) st_next = TX_CR;
        end
        TX_CR:   st_next = RX_IDLE;
        default: st_next = RX_IDLE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= RX_IDLE;
      {cidx_reg, widx_reg, addr_reg, cnt_reg, word_reg} <= '0;
      {chk_reg, rxx_reg, txx_reg, rd_reg, err_reg, ecode_reg} <= '0;
    end else begin
      st_reg <= st_next;
      {cidx_reg, widx_reg, addr_reg, cnt_reg, word_reg} <=
        {cidx_next, widx_next, addr_next, cnt_next, word_next};
      {chk_reg, rxx_reg, txx_reg, rd_reg, err_reg, ecode_reg} <=
        {chk_next, rxx_next, txx_next, rd_next, err_next, ecode_next};
    end
  end

  // Write words are staged so a bad frame never reaches memory
  wire stage_we = take && !is_enq && !is_cr && (st_reg == RX_DATA) &&
                  (cidx_reg == WORD_LAST);
  wire mem_we   = (st_reg == COMMIT);
  wire [AW-1:0] wr_addr = AW'(addr_reg + {8'h00, widx_reg});

  always_ff @(posedge clock) begin
    if (stage_we) stage_mem[widx_reg] <= {word_reg[11:0], nib};
    if (mem_we) panel_word_memory[wr_addr] <= stage_mem[widx_reg];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_frame_end;
    take && st_reg == RX_CR && is_cr;
  endsequence
  sequence s_head_push;
    st_reg == TX_HEAD && push_ok;
  endsequence

  // Parse, reply head and tail, and commit checks
  op_decode_a: assert property (take && st_reg == RX_OP && rx_data == OP_RD
    && !is_enq |=> st_reg == RX_ADDR && rd_reg) else $error("read opcode not decoded");
  cnt_limit_a: assert property (take && st_reg == RX_CNT && cidx_reg == CNT_LAST
    && hx[4] |=> err_reg || cnt_reg <= cnt_lim) else $error("count limit missed");
  read_head_a: assert property (s_head_push ##0 (!err_reg && rd_reg)
    |-> push_data == STX_B ##1 push_data == OP_RD) else $error("bad read head");
  etx_opt_a: assert property (st_reg == TX_ETX |-> bcc_en && !proto_type2)
    else $error("end of text byte misplaced");
  chk_err_a: assert property (bad_chk && !is_enq |=> err_reg && st_reg == RX_CR)
    else $error("check mismatch missed");
  nak_reply_a: assert property (s_frame_end ##0 err_reg |=> st_reg == TX_HEAD
    && push_data == NAK_B) else $error("no negative reply");
  ack_short_a: assert property (s_head_push ##0 (!err_reg && !rd_reg && proto_type2)
    |=> st_reg == RX_IDLE) else $error("type 2 ack too long");
  wr_seq_a: assert property (mem_we && $past(mem_we)
    |-> wr_addr == $past(wr_addr) + 1'b1) else $error("write address not consecutive");
  mem_safe_a: assert property (mem_we |-> !err_reg && !rd_reg)
    else $error("memory written on bad frame");

  // Reply body: write head, error code byte, short forms and word order
  wr_ack_a: assert property (s_head_push ##0 (!err_reg && !rd_reg)
    |-> push_data == ACK_B) else $error("bad write head");
  code_byte_a: assert property (st_reg == TX_CODE |-> push_data == ecode_reg
    && !proto_type2) else $error("error code byte misplaced");
  nak_short_a: assert property (s_head_push ##0 (err_reg && proto_type2)
    |=> st_reg == RX_IDLE) else $error("type 2 negative reply too long");
  data_up_a: assert property (st_reg == TX_DATA && push_ok && cidx_reg == WORD_LAST
    && !last_wd |=> widx_reg == $past(widx_reg) + 8'h01 && st_reg == TX_DATA)
    else $error("read words not in rising order");
endmodule : aml_link

// [tb/aml_host_model.sv]
`timescale 1ns/1ps
// Host side of the link: sends queued request bytes, collects reply bytes
module aml_host_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic       slow    = 1'b0;
  logic       rx_take = 1'b0;
  logic       tx_take = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [2:0] tick;

  initial rx_data = 8'h00;

  // Handshakes judged mid-cycle, where combinational levels have settled
  always @(negedge clock) begin
    rx_take = rx_valid && rx_ready;
    tx_take = tx_valid && tx_ready;
    tx_byte = tx_data;
  end

  // Bytes move on only after the edge that took them
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
      tick     <= 3'h0;
    end else begin
      tick     <= tick + 3'h1;
      tx_ready <= !slow || (tick == 3'h0); // Slow mode stalls seven cycles in eight
      if (tx_take) got_q.push_back(tx_byte);
      if (rx_take) void'(send_q.pop_front());
      rx_valid <= (send_q.size() != 0);
      // Released data line inverts every cycle, so the last byte returns every other cycle
      rx_data  <= (send_q.size() != 0) ? send_q[0] : ~rx_data;
    end
  end
endmodule : aml_host_model

// [tb/test_aml_link.sv]
`timescale 1ns/1ps
module test_aml_link import aml_pkg::*;;
  localparam int LIMIT = 30000;
  logic        clock       = 1'b0;
  logic        rst_n       = 1'b0;
  logic        bcc_en      = 1'b0;
  logic        proto_type2 = 1'b0;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic [7:0]  fr[$];
  logic [7:0]  ex[$];
  logic [15:0] mem [0:1023];
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          cyc        = 0;

  always #4 clock = ~clock;

  aml_link #(.AW(10), .MAX_WORDS_P(MAX_WORDS), .DEPTH(FIFO_DEPTH)) aml_link_i (
    .clock(clock), .rst_n(rst_n), .bcc_en(bcc_en), .proto_type2(proto_type2),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  aml_host_model aml_host_model_i (
    .clock(clock), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Value as upper-case ASCII hex, most significant nibble first
  function automatic void hexq(ref logic [7:0] q[$], input logic [15:0] v, input int n);
    logic [3:0] d;
    for (int i = n - 1; i >= 0; i--) begin
      d = v[4*i +: 4];
      q.push_back(d < 4'hA ? 8'h30 + 8'(d) : 8'h37 + 8'(d));
    end
  endfunction : hexq

  // XOR of every byte so far, appended as two hex characters
  function automatic void add_chk(ref logic [7:0] q[$]);
    logic [7:0] x;
    x = 8'h00;
    foreach (q[i]) x ^= q[i];
    hexq(q, {8'h00, x}, 2);
  endfunction : add_chk

  function automatic void hdr(input logic [7:0] op, input logic [15:0] a, input int n);
    fr = {ENQ_B, op};
    hexq(fr, a, 4);
    hexq(fr, 16'(n), 2);
  endfunction : hdr

  function automatic void nak(input logic [7:0] code);
    ex = {NAK_B};
    if (!proto_type2) ex = {ex, code, CR_B};
  endfunction : nak

  task automatic set_mode(input logic b, input logic t);
    @(posedge clock);
    bcc_en      <= b;
    proto_type2 <= t;
    @(posedge clock);
  endtask : set_mode

  // One request, then wait for the whole reply before anything else is sent
  task automatic run(input logic bad);
    if (bcc_en) add_chk(fr);
    if (bad) fr[fr.size()-1] = (fr[fr.size()-1] == 8'h30) ? 8'h31 : 8'h30;
    fr.push_back(CR_B);
    foreach (fr[i]) aml_host_model_i.send_q.push_back(fr[i]);
    // A reply that never completes is ended by the cycle ceiling below
    do begin
      @(negedge clock);
    end while (!(aml_host_model_i.got_q.size() >= ex.size() && rx_ready === 1'b1
                 && tx_valid === 1'b0 && aml_host_model_i.send_q.size() == 0));
    check(16'(aml_host_model_i.got_q.size()), 16'(ex.size()), "reply length");
    foreach (ex[i]) check({8'h00, aml_host_model_i.got_q[i]}, {8'h00, ex[i]}, "reply byte");
    aml_host_model_i.got_q.delete();
  endtask : run

  task automatic wr(input logic [15:0] a, input int n, input logic bad, input logic [15:0] s);
    logic [15:0] v;
    hdr(OP_WR, a, n);
    for (int i = 0; i < n; i++) begin
      v = s + 16'(i) * 16'h1111;
      hexq(fr, v, 4);
      if (!bad) mem[a[9:0] + 10'(i)] = v;
    end
    ex = {ACK_B};
    if (!proto_type2) ex = {ex, OP_WR, CR_B};
    if (bad) nak(EC_CHK);
    run(bad);
  endtask : wr

  task automatic rd(input logic [15:0] a, input int n, input logic bad);
    hdr(OP_RD, a, n);
    ex = {STX_B, OP_RD};
    hexq(ex, a, 4);
    hexq(ex, 16'(n), 2);
    for (int i = 0; i < n; i++) hexq(ex, mem[a[9:0] + 10'(i)], 4);
    if (bcc_en && !proto_type2) ex.push_back(ETX_B);
    if (bcc_en) add_chk(ex);
    ex.push_back(CR_B);
    if (bad) nak(EC_CHK);
    run(bad);
  endtask : rd

  task automatic t_basic();
    set_mode(1'b0, 1'b0);
    wr(16'h00C8, 3, 1'b0, 16'h1357);
    rd(16'h00C8, 3, 1'b0);
    rd(16'h00C8, 0, 1'b0);
    // Short forms without check, words wrapping past the top address
    set_mode(1'b0, 1'b1);
    wr(16'h03FF, 2, 1'b0, 16'hFEDC);
    rd(16'h03FF, 2, 1'b0);
    $display("t_basic done");
  endtask : t_basic

  // Check field under both reply formats, good and corrupted
  task automatic t_check();
    for (int t = 0; t < 2; t++) begin
      set_mode(1'b1, t[0]);
      wr(16'h0040, 2, 1'b0, 16'hA5C3 + 16'(t));
      rd(16'h0040, 2, 1'b0);
      wr(16'h0040, 2, 1'b1, 16'h0F0F);
      rd(16'h0040, 2, 1'b1);
      rd(16'h0040, 2, 1'b0);
    end
    $display("t_check done");
  endtask : t_check

  task automatic t_bad_frames();
    set_mode(1'b0, 1'b0);
    fr = {ENQ_B, OP_RD, 8'h30, 8'h30, 8'h47, 8'h30, 8'h30, 8'h31};
    nak(EC_HEX);
    run(1'b0);
    hdr(OP_WR, 16'h00C8, 1);
    // Leading junk before the start byte must be ignored
    fr = {8'h41, fr, 8'h5A, 8'h31, 8'h32, 8'h33};
    nak(EC_HEX);
    run(1'b0);
    hdr(8'h51, 16'h00C8, 1);
    nak(EC_OP);
    run(1'b0);
    // Frame cut short, then a stray byte where the end byte belongs
    fr = {ENQ_B, OP_WR, 8'h30, 8'h30};
    nak(EC_FRAME);
    run(1'b0);
    hdr(OP_RD, 16'h00C8, 1);
    fr.push_back(8'h30);
    nak(EC_FRAME);
    run(1'b0);
    rd(16'h00C8, 3, 1'b0);
    $display("t_bad_frames done");
  endtask : t_bad_frames

  // Largest count, reply far longer than the buffer, host stalling
  task automatic t_max_stall();
    set_mode(1'b1, 1'b0);
    wr(16'h0100, 255, 1'b0, 16'h2468);
    aml_host_model_i.slow = 1'b1;
    rd(16'h0100, 255, 1'b0);
    aml_host_model_i.slow = 1'b0;
    $display("t_max_stall done");
  endtask : t_max_stall

  // Cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("[FAIL] %0t run timed out", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_basic();
    t_check();
    t_bad_frames();
    t_max_stall();
    wrap_up();
  end
endmodule : test_aml_link
